// [hdl/i2csr_bus_if.sv]
`timescale 1ns/1ps
// two-wire bus: host drives four signals, device two, open drain resolved here
interface i2csr_bus_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // pull-up wins unless some party drives low
  assign scl = ~(~host_scl_oe_n & ~host_scl_o);
  assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));

  modport device (
    input scl,
    input sda,
    output dev_sda_o,
    output dev_sda_oe_n
  );

  modport host (
    input scl,
    input sda,
    output host_scl_o,
    output host_scl_oe_n,
    output host_sda_o,
    output host_sda_oe_n
  );
endinterface : i2csr_bus_if

// [hdl/i2csr_defines.svh]
`ifndef I2CSR_DEFINES_SVH
`define I2CSR_DEFINES_SVH

// ----------------------------------------------------------------
// slave addresses (8-bit forms with r/w bit included, plus the 7-bit form)
// ----------------------------------------------------------------
`define I2CSR_WRITE_ADDR 8'h90
`define I2CSR_READ_ADDR 8'h91
`define I2CSR_ADDR7 7'h48

// ----------------------------------------------------------------
// bus recovery and host timing
// ----------------------------------------------------------------
`define I2CSR_RECOVERY_PULSES 4'hA
`define I2CSR_CLK_MHZ 25
`define I2CSR_SCL_KHZ 100
`define I2CSR_QUARTER_CYCLES (`I2CSR_CLK_MHZ * 1000 / (`I2CSR_SCL_KHZ * 4))

`endif

// [hdl/i2csr_device.sv]
// Contract
// - data changes only while clock low
// - acknowledge each accepted byte by pulling low
// - host gives ninth pulse for acknowledge
// - release data line after every acknowledge
// - read: address, command, repeated start, read
// - valid command loads pointer and acknowledges
// - invalid command keeps pointer, not acknowledged
// - write commits only at data acknowledge
// - start/stop before ack end cancels write
// - start or stop ends any sequence
// - read returns register at pointer
// - stop returns to idle, ignore until start
// - repeated start handled as ordinary start
// - foreign slave address not acknowledged
// - read-only write: ack command, nack data
// - pointer kept after refused read-only write
// - answer only addresses 0x90 and 0x91
// - ten clock pulses release stuck data line
// - device never creates start or stop
`timescale 1ns/1ps
`include "i2csr_defines.svh"
module i2csr_device (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // bus side
  i2csr_bus_if.device bus,
  // register access side
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  input wire logic [7:0] rd_data,
  input wire logic reg_readable,
  input wire logic reg_writable,
  // status
  output logic busy
);

  typedef enum logic [3:0] {
    I2CSR_WAIT, I2CSR_ADDR, I2CSR_ADDR_ACK, I2CSR_CMD, I2CSR_CMD_ACK,
    I2CSR_DATA_IN, I2CSR_DATA_ACK, I2CSR_TX, I2CSR_TX_ACK, I2CSR_IGNORE
  } i2csr_dev_state_type;

  // ----------------------------------------------------------------
  // line sampling
  // ----------------------------------------------------------------
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_q;
  logic sda_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], bus.scl};
      sda_sync <= {sda_sync[1:0], bus.sda};
    end
  end

  // filtered level changes only when stages two and three agree
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      if (scl_sync[1] == scl_sync[2]) scl_q <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2]) sda_q <= sda_sync[2];
    end
  end

  logic scl_prev;
  logic sda_prev;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_q;
      sda_prev <= sda_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise = scl_q & ~scl_prev;
  assign scl_fall = ~scl_q & scl_prev;
  assign start_det = scl_q & scl_prev & sda_prev & ~sda_q;
  assign stop_det = scl_q & scl_prev & ~sda_prev & sda_q;

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  i2csr_dev_state_type state;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic ack_low;
  logic drive_low;
  logic [3:0] pulse_cnt;
  logic got_bit;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= I2CSR_WAIT;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
      ack_low <= 1'b0;
      got_bit <= 1'b0;
    end else if (start_det) begin
      // a pending write dies here before its ack pulse ends
      state <= I2CSR_ADDR;
      bit_cnt <= 3'h0;
      got_bit <= 1'b0;
      ack_low <= 1'b0;
    end else if (stop_det) begin
      state <= I2CSR_WAIT;
      ack_low <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        I2CSR_ADDR, I2CSR_CMD, I2CSR_DATA_IN: begin
          shift <= {shift[6:0], sda_q};
          bit_cnt <= bit_cnt + 3'h1;
          got_bit <= 1'b1;
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state)
        // the clock fall right after a start carries no bit
        I2CSR_ADDR: if (bit_cnt == 3'h0 && got_bit) begin
          state <= I2CSR_ADDR_ACK;
          got_bit <= 1'b0;
          ack_low <= (shift == `I2CSR_WRITE_ADDR) || (shift == `I2CSR_READ_ADDR);
        end
        I2CSR_ADDR_ACK: begin
          ack_low <= 1'b0;
          if (!ack_low) state <= I2CSR_IGNORE;
          else if (shift[0]) begin
            state <= I2CSR_TX;
            shift <= rd_data;
          end else state <= I2CSR_CMD;
        end
        I2CSR_CMD: if (bit_cnt == 3'h0) begin
          state <= I2CSR_CMD_ACK;
          ack_low <= reg_readable;
        end
        I2CSR_CMD_ACK: begin
          ack_low <= 1'b0;
          state <= ack_low ? I2CSR_DATA_IN : I2CSR_WAIT;
        end
        I2CSR_DATA_IN: if (bit_cnt == 3'h0) begin
          state <= I2CSR_DATA_ACK;
          ack_low <= reg_writable;
        end
        I2CSR_DATA_ACK: begin
          ack_low <= 1'b0;
          state <= I2CSR_WAIT;
        end
        I2CSR_TX: begin
          bit_cnt <= bit_cnt + 3'h1;
          shift <= {shift[6:0], 1'b0};
          if (bit_cnt == 3'h7) state <= I2CSR_TX_ACK;
        end
        I2CSR_TX_ACK: begin
          bit_cnt <= 3'h0;
          state <= I2CSR_WAIT;
        end
        default: ;
      endcase
    end
  end

  // pointer: loaded on the command byte, only if readable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_addr <= 8'h00;
    end else if (scl_fall && state == I2CSR_CMD && bit_cnt == 3'h0 && reg_readable) begin
      reg_addr <= shift;
    end
  end

  // commit on the falling edge that ends the data acknowledge pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_data <= 8'h00;
      wr_strobe <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      if (scl_fall && !start_det && !stop_det && state == I2CSR_DATA_ACK && ack_low) begin
        wr_data <= shift;
        wr_strobe <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // data line drive and recovery
  // ----------------------------------------------------------------
  logic tx_bit;
  logic want_low;
  assign tx_bit = (state == I2CSR_TX) && !shift[7];
  assign want_low = ack_low || tx_bit;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt <= 4'h0;
    end else if (start_det || stop_det || !want_low) begin
      pulse_cnt <= 4'h0;
    end else if (scl_rise && pulse_cnt != `I2CSR_RECOVERY_PULSES) begin
      pulse_cnt <= pulse_cnt + 4'h1;
    end
  end

  // changes only follow a falling clock, never make start/stop
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      drive_low <= 1'b0;
    end else if (start_det || stop_det) begin
      drive_low <= 1'b0;
    end else if (!scl_q) begin
      // recovery release also waits for a low clock
      drive_low <= want_low && pulse_cnt != `I2CSR_RECOVERY_PULSES;
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = ~drive_low;
  assign busy = (state != I2CSR_WAIT);
endmodule : i2csr_device

// [hdl/i2csr_host.sv]
`timescale 1ns/1ps
`include "i2csr_defines.svh"
module i2csr_host #(
  parameter int QUARTER = `I2CSR_QUARTER_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // bus side
  i2csr_bus_if.host bus,
  // command side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire i2csr_pkg::i2csr_op_type cmd_op,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_data,
  output logic done,
  output i2csr_pkg::i2csr_result_type result,
  output logic [7:0] read_data
);

  typedef enum logic [2:0] {
    I2CSR_H_IDLE, I2CSR_H_START, I2CSR_H_BIT, I2CSR_H_STOP, I2CSR_H_DONE
  } i2csr_host_state_type;

  // ----------------------------------------------------------------
  // quarter-period tick
  // ----------------------------------------------------------------
  logic [15:0] div;
  logic tick;
  assign tick = (div == 16'(QUARTER - 1));
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) div <= 16'h0000;
    else div <= tick ? 16'h0000 : div + 16'h0001;
  end

  // ----------------------------------------------------------------
  // bit sequencer: each bit is four quarters, scl high in 2 and 3
  // ----------------------------------------------------------------
  i2csr_host_state_type state;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [1:0] byten;
  logic [1:0] nbytes;
  logic [8:0] sh;
  logic [7:0] rx;
  i2csr_pkg::i2csr_op_type op;
  logic [7:0] reg_q;
  logic [7:0] dat_q;
  logic scl_lo;
  logic sda_lo;
  logic rd_phase;

  // byte image for a given byte slot; ninth bit is the ack slot
  function automatic logic [8:0] byte_image(input logic [1:0] n, input logic rdp);
    byte_image = 9'h1FF;
    case (n)
      2'h0: byte_image = {rdp ? `I2CSR_READ_ADDR : `I2CSR_WRITE_ADDR, 1'b1};
      2'h1: byte_image = {reg_q, 1'b1};
      2'h2: byte_image = {dat_q, 1'b1};
      default: byte_image = 9'h1FF;
    endcase
  endfunction : byte_image

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= I2CSR_H_IDLE;
      phase <= 2'h0;
      bitn <= 4'h0;
      byten <= 2'h0;
      nbytes <= 2'h0;
      sh <= 9'h1FF;
      rx <= 8'h00;
      op <= i2csr_pkg::I2CSR_OP_WRITE;
      reg_q <= 8'h00;
      dat_q <= 8'h00;
      scl_lo <= 1'b0;
      sda_lo <= 1'b0;
      rd_phase <= 1'b0;
      done <= 1'b0;
      result <= i2csr_pkg::I2CSR_RES_ACK;
      read_data <= 8'h00;
    end else begin
      done <= 1'b0;
      case (state)
        I2CSR_H_IDLE: if (cmd_valid) begin
          op <= cmd_op;
          reg_q <= cmd_reg;
          dat_q <= cmd_data;
          rd_phase <= 1'b0;
          nbytes <= (cmd_op == i2csr_pkg::I2CSR_OP_WRITE) ? 2'h3 : 2'h2;
          result <= i2csr_pkg::I2CSR_RES_ACK;
          phase <= 2'h0;
          state <= I2CSR_H_START;
        end
        I2CSR_H_START: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              scl_lo <= 1'b0;
              sda_lo <= 1'b0;
            end
            2'h1: sda_lo <= 1'b1; // start: data falls with clock high
            2'h2: scl_lo <= 1'b1;
            default: begin
              state <= I2CSR_H_BIT;
              bitn <= 4'h0;
              byten <= 2'h0;
              sh <= byte_image(2'h0, rd_phase);
            end
          endcase
        end
        I2CSR_H_BIT: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              sda_lo <= ~sh[8];
              if (rd_phase && byten == 2'h1 && bitn == 4'h8) sda_lo <= 1'b0;
              if (rd_phase && byten == 2'h1 && bitn != 4'h8) sda_lo <= 1'b0;
            end
            2'h1: scl_lo <= 1'b0;
            2'h2: if (bitn == 4'h8) begin
              if (bus.sda && !(rd_phase && byten == 2'h1)) begin
                if (byten == 2'h0) result <= i2csr_pkg::I2CSR_RES_NACK_ADDR;
                else if (byten == 2'h1) result <= i2csr_pkg::I2CSR_RES_NACK_CMD;
                else result <= i2csr_pkg::I2CSR_RES_NACK_DATA;
              end
            end else rx <= {rx[6:0], bus.sda};
            default: begin
              scl_lo <= 1'b1;
              sh <= {sh[7:0], 1'b1};
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                bitn <= 4'h0;
                byten <= byten + 2'h1;
                sh <= byte_image(byten + 2'h1, rd_phase);
                if (result != i2csr_pkg::I2CSR_RES_ACK || byten + 2'h1 == nbytes) begin
                  if (rd_phase) read_data <= rx;
                  if (op == i2csr_pkg::I2CSR_OP_READ && !rd_phase &&
                      result == i2csr_pkg::I2CSR_RES_ACK) begin
                    rd_phase <= 1'b1; // repeated start
                    state <= I2CSR_H_START;
                  end else state <= I2CSR_H_STOP;
                end
              end
            end
          endcase
        end
        I2CSR_H_STOP: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: sda_lo <= 1'b1;
            2'h1: scl_lo <= 1'b0;
            2'h2: sda_lo <= 1'b0; // stop: data rises with clock high
            default: state <= I2CSR_H_DONE;
          endcase
        end
        default: begin
          done <= 1'b1;
          state <= I2CSR_H_IDLE;
        end
      endcase
    end
  end

  assign cmd_ready = (state == I2CSR_H_IDLE);
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe_n = ~scl_lo;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe_n = ~sda_lo;
endmodule : i2csr_host

// [hdl/i2csr_pkg.sv]
package i2csr_pkg;
  typedef enum logic [1:0] {
    I2CSR_OP_WRITE,
    I2CSR_OP_READ,
    I2CSR_OP_SET_POINTER
  } i2csr_op_type;

  typedef enum logic [1:0] {
    I2CSR_RES_ACK,
    I2CSR_RES_NACK_ADDR,
    I2CSR_RES_NACK_CMD,
    I2CSR_RES_NACK_DATA
  } i2csr_result_type;
endpackage : i2csr_pkg

// [verif/i2c_slave_register_access_tb_top.sv]
`timescale 1ns/1ps
module i2c_slave_register_access_tb_top;
  logic core_clk;
  logic rstn;
  logic cmd_valid;
  logic cmd_ready;
  logic done;
  logic wr_strobe;
  logic wr_strobe2;
  logic a;
  logic s;
  logic busy2;
  i2csr_pkg::i2csr_op_type cmd_op;
  i2csr_pkg::i2csr_result_type result;
  logic [7:0] cmd_reg, cmd_data, read_data, reg_addr, wr_data, cur_cmd, reg_addr2, wr_data2, rd2;
  logic [7:0] regs [0:63];
  int fails = 0;
  int tests_run = 0;
  int strobes = 0;
  int strobes2 = 0;
  int cycles = 0;
  i2csr_bus_if bus1();
  i2csr_bus_if bus2();

  i2csr_host #(.QUARTER(8)) i2csr_host_i (.core_clk(core_clk), .rstn(rstn), .bus(bus1),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_reg(cmd_reg),
    .cmd_data(cmd_data), .done(done), .result(result), .read_data(read_data));
  i2csr_device i2csr_device_i (.core_clk(core_clk), .rstn(rstn), .bus(bus1),
    .reg_addr(reg_addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_data(regs[reg_addr[5:0]]), .reg_readable(cur_cmd >= 8'h02 && cur_cmd <= 8'h27),
    .reg_writable(reg_addr != 8'h02 && reg_addr != 8'h0A), .busy());
  // second device faces the bench's own bit-level driver and reads back its pointer
  i2csr_device i2csr_device_i2 (.core_clk(core_clk), .rstn(rstn), .bus(bus2),
    .reg_addr(reg_addr2), .wr_data(wr_data2), .wr_strobe(wr_strobe2), .rd_data(reg_addr2),
    .reg_readable(1'b1), .reg_writable(reg_addr2 != 8'h02), .busy(busy2));
  i2csr_sva i2csr_sva_i (.core_clk(core_clk), .rstn(rstn), .scl(bus1.scl), .sda(bus1.sda),
    .dev_sda_oe_n(bus1.dev_sda_oe_n));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // register file model and run limit
  always @(posedge core_clk) begin
    if (wr_strobe === 1'b1) begin
      regs[reg_addr[5:0]] <= wr_data;
      strobes++;
    end
    if (wr_strobe2 === 1'b1) strobes2++;
    cycles++;
    if (cycles == 60000) begin
      fails++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task chk_res(input i2csr_pkg::i2csr_result_type e);
    chk("result", {6'h00, result}, {6'h00, e});
  endtask : chk_res

  task run_cmd(input i2csr_pkg::i2csr_op_type op, input logic [7:0] r, input logic [7:0] d);
    @(negedge core_clk);
    cur_cmd = r;
    cmd_op = op;
    cmd_reg = r;
    cmd_data = d;
    cmd_valid = 1'b1;
    // a hang here runs into the cycle ceiling, which fails the run
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1) @(negedge core_clk);
  endtask : run_cmd

  task bb_q;
    repeat (8) @(negedge core_clk);
  endtask : bb_q

  task bb_bit(input logic b, output logic smp);
    bus2.host_sda_oe_n = b;
    bb_q();
    bus2.host_scl_oe_n = 1'b1;
    bb_q();
    smp = bus2.sda;
    bb_q();
    bus2.host_scl_oe_n = 1'b0;
    bb_q();
  endtask : bb_bit

  task bb_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) bb_bit(v[i], s);
    bb_bit(1'b1, ack);
  endtask : bb_byte

  task bb_start;
    bus2.host_sda_oe_n = 1'b1;
    bb_q();
    bus2.host_scl_oe_n = 1'b1;
    bb_q();
    bus2.host_sda_oe_n = 1'b0;
    bb_q();
    bus2.host_scl_oe_n = 1'b0;
    bb_q();
  endtask : bb_start

  task bb_stop;
    bus2.host_sda_oe_n = 1'b0;
    bb_q();
    bus2.host_scl_oe_n = 1'b1;
    bb_q();
    bus2.host_sda_oe_n = 1'b1;
    bb_q();
  endtask : bb_stop

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_write_read;
    run_cmd(i2csr_pkg::I2CSR_OP_WRITE, 8'h05, 8'hA5);
    chk_res(i2csr_pkg::I2CSR_RES_ACK);
    chk("reg 05", regs[5], 8'hA5);
    run_cmd(i2csr_pkg::I2CSR_OP_READ, 8'h05, 8'h00);
    chk_res(i2csr_pkg::I2CSR_RES_ACK);
    chk("read data", read_data, 8'hA5);
    run_cmd(i2csr_pkg::I2CSR_OP_WRITE, 8'h10, 8'h3C);
    run_cmd(i2csr_pkg::I2CSR_OP_WRITE, 8'h11, 8'hC3);
    chk("reg 10", regs[16], 8'h3C);
    chk("reg 11", regs[17], 8'hC3);
  endtask : t_write_read

  task t_bad_cmd;
    run_cmd(i2csr_pkg::I2CSR_OP_SET_POINTER, 8'h05, 8'h00);
    chk("pointer", reg_addr, 8'h05);
    run_cmd(i2csr_pkg::I2CSR_OP_WRITE, 8'h01, 8'h77);
    chk_res(i2csr_pkg::I2CSR_RES_NACK_CMD);
    run_cmd(i2csr_pkg::I2CSR_OP_SET_POINTER, 8'h30, 8'h00);
    chk_res(i2csr_pkg::I2CSR_RES_NACK_CMD);
    chk("pointer kept", reg_addr, 8'h05);
    chk("reg 01", regs[1], 8'h41);
  endtask : t_bad_cmd

  task t_read_only;
    run_cmd(i2csr_pkg::I2CSR_OP_WRITE, 8'h02, 8'h3C);
    chk_res(i2csr_pkg::I2CSR_RES_NACK_DATA);
    chk("ro pointer", reg_addr, 8'h02);
    chk("ro strobes", 8'(strobes), 8'h03);
    run_cmd(i2csr_pkg::I2CSR_OP_READ, 8'h02, 8'h00);
    chk("ro data", read_data, 8'h42);
  endtask : t_read_only

  task t_wire;
    bb_start();
    bb_byte(8'h92, a);
    chk("foreign nack", {7'h00, a}, 8'h01);
    bb_start();
    bb_byte(8'h00, a);
    chk("general nack", {7'h00, a}, 8'h01);
    bb_start();
    bb_byte(8'h90, a);
    chk("addr ack", {7'h00, a}, 8'h00);
    bb_byte(8'h05, a);
    for (int i = 7; i >= 1; i--) bb_bit(i[0], s);
    bb_stop();
    chk("cancel", 8'(strobes2), 8'h00);
    chk("idle busy", {7'h00, busy2}, 8'h00);
    bb_start();
    bb_byte(8'h90, a);
    bb_byte(8'h05, a);
    bb_start();
    bb_byte(8'h92, a);
    chk("restart nack", {7'h00, a}, 8'h01);
    bb_stop();
    bus2.host_scl_oe_n = 1'b0;
    bb_q();
    bb_byte(8'h90, a);
    chk("idle ignore", {7'h00, a}, 8'h01);
    bb_start();
    bb_byte(8'h90, a);
    bb_byte(8'h05, a);
    bb_byte(8'h5A, a);
    bb_stop();
    chk("data ack", {7'h00, a}, 8'h00);
    chk("commit", 8'(strobes2), 8'h01);
    chk("commit data", wr_data2, 8'h5A);
    bb_start();
    bb_byte(8'h90, a);
    bb_byte(8'h02, a);
    bb_byte(8'h3C, a);
    chk("ro nack", {7'h00, a}, 8'h01);
    bb_start();
    bb_byte(8'h91, a);
    for (int i = 7; i >= 0; i--) bb_bit(1'b1, rd2[i]);
    bb_bit(1'b1, s);
    bb_stop();
    chk("ro read", rd2, 8'h02);
    bb_start();
    bb_byte(8'h91, a);
    chk("held low", {7'h00, bus2.sda}, 8'h00);
    repeat (10) bb_bit(1'b1, s);
    chk("released", {7'h00, bus2.sda}, 8'h01);
    bb_stop();
  endtask : t_wire

  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = i2csr_pkg::I2CSR_OP_WRITE;
    cmd_reg = 8'h00;
    cmd_data = 8'h00;
    cur_cmd = 8'h00;
    bus2.host_scl_o = 1'b0;
    bus2.host_sda_o = 1'b0;
    bus2.host_scl_oe_n = 1'b1;
    bus2.host_sda_oe_n = 1'b1;
    for (int i = 0; i < 64; i++) regs[i] = 8'(i) + 8'h40;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    chk("reset pointer", reg_addr, 8'h00);
    t_write_read();
    t_bad_cmd();
    t_read_only();
    t_wire();
    test_done();
  end
endmodule : i2c_slave_register_access_tb_top

// [verif/i2csr_sva.sv]
`timescale 1ns/1ps
module i2csr_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // bus lines
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe_n
);
  logic scl_q;
  logic sda_q;
  logic first;
  logic [3:0] bits;
  logic [3:0] hold;
  logic [7:0] shr;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  wire rise = scl && !scl_q;
  wire fall = !scl && scl_q;
  wire own = shr == 8'h90 || shr == 8'h91;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // bus tracking
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // bit count and shifted byte of the frame after each start
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bits <= 4'h0;
      first <= 1'b0;
      shr <= 8'h00;
    end else if (start) begin
      bits <= 4'h0;
      first <= 1'b1;
    end else if (stop) begin
      first <= 1'b0;
    end else if (rise && bits < 4'h9) begin
      bits <= bits + 4'h1;
      if (bits < 4'h8) begin
        shr <= {shr[6:0], sda};
      end
    end else if (fall && bits == 4'h9) begin
      bits <= 4'h0;
      first <= 1'b0;
    end
  end

  // clock pulses seen while the device holds data low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hold <= 4'h0;
    end else if (dev_sda_oe_n) begin
      hold <= 4'h0;
    end else if (rise) begin
      hold <= hold + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_dev_stable_high;
    scl && scl_q |-> $stable(dev_sda_oe_n);
  endproperty
  a_dev_stable_high: assert property (p_dev_stable_high)
    else $error("device data drive changed while clock high");
  property p_dev_pull_low;
    $fell(dev_sda_oe_n) |-> !scl && !scl_q;
  endproperty
  a_dev_pull_low: assert property (p_dev_pull_low)
    else $error("device pulled data low while clock high");
  property p_addr_quiet;
    first && bits < 4'h8 |-> dev_sda_oe_n;
  endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("device drove data during address bits");
  property p_addr_ack;
    rise && first && bits == 4'h8 |-> sda == !own;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address acknowledge slot wrong");
  property p_ack_release;
    fall && first && bits == 4'h9 && shr == 8'h90 |-> ##[1:8] dev_sda_oe_n;
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("data line not released after acknowledge");
  property p_stop_idle;
    stop |=> dev_sda_oe_n [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("device drove data after stop");
  property p_hold_limit;
    hold <= 4'hA;
  endproperty
  a_hold_limit: assert property (p_hold_limit)
    else $error("data held low for too many pulses");
  property p_scl_pulse;
    $rose(scl) |-> scl [*4];
  endproperty
  a_scl_pulse: assert property (p_scl_pulse)
    else $error("clock high pulse too short");
endmodule : i2csr_sva
